// ==== common/intvec_pkg.sv ====
package intvec_pkg;

    // maskable vector slots, slot 0 is the highest maskable priority
    localparam int NUM_SLOTS = 20;
    localparam int SLOT_FLAG_W = 16;
    localparam int FLAG_BUS_W = 73;
    localparam int NUM_SNMI = 9;
    localparam int NUM_UNMI = 4;
    localparam int NUM_RST = 7;

    // where each slot's module flags sit on the flat maskable flag bus
    localparam int SLOT_OFF [NUM_SLOTS] = '{0, 2, 3, 10, 11, 13, 15, 31, 32, 37,
                                            37, 40, 41, 44, 52, 54, 56, 57, 60, 68};
    localparam int SLOT_W [NUM_SLOTS] = '{2, 1, 7, 1, 2, 2, 16, 1, 5, 0,
                                          3, 1, 3, 8, 2, 2, 1, 3, 8, 5};
    localparam int SLOT_WDT = 3;
    localparam int SLOT_CONV = 6;
    localparam int SLOT_RSVD = 9;

    // vector word addresses
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_SNMI = 16'hFFFC;
    localparam logic [15:0] VEC_UNMI = 16'hFFFA;
    localparam logic [15:0] VEC_MASK_TOP = 16'hFFF8;
    localparam logic [15:0] VEC_MASK_LOW = 16'hFFD2;
    localparam logic [15:0] VEC_FREE_TOP = 16'hFFD0;
    localparam logic [15:0] VEC_LOWEST = 16'hFF80;

    // priorities
    localparam logic [5:0] PRIO_RESET = 6'h3F;
    localparam logic [5:0] PRIO_SNMI = 6'h3E;
    localparam logic [5:0] PRIO_UNMI = 6'h3D;
    localparam logic [5:0] PRIO_MASK_TOP = 6'h3C;
    localparam logic [5:0] PRIO_MASK_LOW = 6'h29;

    // reset cause bit positions
    localparam int RC_POWER_UP = 0;
    localparam int RC_PIN = 1;
    localparam int RC_WDT_TIMEOUT = 2;
    localparam int RC_WDT_PASSWORD = 3;
    localparam int RC_FLASH_KEY = 4;
    localparam int RC_PMM_PASSWORD = 5;
    localparam int RC_FETCH = 6;
    localparam logic [6:0] RST_CAUSE_RESET = 7'h01;

    // vector word select codes
    localparam logic [4:0] SEL_RESET = 5'h00;
    localparam logic [4:0] SEL_SNMI = 5'h01;
    localparam logic [4:0] SEL_UNMI = 5'h02;
    localparam logic [4:0] SEL_SLOT0 = 5'h03;

    // address map used for fetch checking
    localparam logic [19:0] PERIPH_TOP = 20'h0_0FFF;
    localparam logic [19:0] VACANT_LO = 20'h0_1A00;
    localparam logic [19:0] VACANT_HI = 20'h0_1BFF;
    localparam logic [19:0] RAM_TOP_DEF = 20'h0_43FF;
    localparam logic [19:0] FLASH_BASE = 20'h0_4400;
    localparam logic [19:0] FLASH_TOP_DEF = 20'h2_43FF;

    typedef enum logic [0:0] {
        ARB_IDLE = 1'b0,
        ARB_PEND = 1'b1
    } arb_state_e;

endpackage

// ==== logic/interrupt_vector_priority_map.sv ====
`timescale 1ns/1ps

module interrupt_vector_priority_map #(
    parameter bit HAS_CONVERTER = 1'b1,
    parameter logic [19:0] RAM_TOP = intvec_pkg::RAM_TOP_DEF,
    parameter logic [19:0] FLASH_TOP = intvec_pkg::FLASH_TOP_DEF
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic rst_pin_n_in,
    input wire logic wdt_interval_mode_in,
    input wire logic watchdog_flag_in,
    input wire logic wdt_password_in,
    input wire logic flash_key_violation_flag_in,
    input wire logic pmm_password_in,
    input wire logic [8:0] snmi_flags_in,
    input wire logic [8:0] snmi_enable_in,
    input wire logic [3:0] unmi_flags_in,
    input wire logic [3:0] unmi_enable_in,
    input wire logic [72:0] maskable_flags_in,
    input wire logic [72:0] maskable_enable_in,
    input wire logic gie_in,
    input wire logic lpm_in,
    input wire logic fetch_valid_in,
    input wire logic [19:0] fetch_addr_in,
    input wire logic irq_ack_in,
    input wire logic [4:0] vw_sel_in,
    input wire logic vw_read_in,
    output logic irq_req_out,
    output logic [15:0] irq_vector_out,
    output logic [5:0] irq_priority_out,
    output logic reset_req_out,
    output logic [15:0] reset_vector_out,
    output logic wake_out,
    output logic [15:0] vw_data_out
);

    // index plus one of the lowest set bit, zero when nothing is set
    function automatic logic [5:0] first_set(input logic [31:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int k = 31; k >= 0; k--) begin
            if (v[k]) begin
                r = 6'(k + 1);
            end
        end
        return r;
    endfunction

    // vector word code for a first_set result: even numbers, zero means none
    function automatic logic [15:0] word_code(input logic [5:0] idx);
        return {9'h000, idx, 1'b0};
    endfunction

    logic pin_meta;
    logic pin_sync;
    logic [6:0] reset_cause;
    intvec_pkg::arb_state_e state;
    intvec_pkg::arb_state_e next_state;

    wire logic wdt_timeout;
    wire logic wdt_interval_flag;
    wire logic fetch_illegal;
    wire logic [6:0] rst_events;
    wire logic [5:0] cause_first;
    wire logic [6:0] cause_clear;
    wire logic [8:0] snmi_active;
    wire logic [3:0] unmi_active;
    wire logic [72:0] wdt_mask;
    wire logic [72:0] flags_routed;
    wire logic [72:0] active_flags;
    wire logic [15:0] slot_flags [intvec_pkg::NUM_SLOTS];
    wire logic [15:0] slot_word [intvec_pkg::NUM_SLOTS];
    wire logic [19:0] slot_pend;
    wire logic [5:0] best_slot;
    wire logic [4:0] best_idx;
    wire logic mask_req;
    wire logic cand_valid;
    wire logic [15:0] cand_vector;
    wire logic [5:0] cand_prio;
    wire logic [4:0] slot_sel;
    wire logic [15:0] next_vw;

    // reset pin is asynchronous to mclk, two flops before any use
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= rst_pin_n_in;
            pin_sync <= pin_meta;
        end
    end

    // watchdog flag routing depends on its mode
    assign wdt_timeout = watchdog_flag_in & ~wdt_interval_mode_in;
    assign wdt_interval_flag = watchdog_flag_in & wdt_interval_mode_in;

    // fetch checking: peripheral space, the hole above info memory, the gap
    // above populated RAM and anything above populated flash are all vacant
    assign fetch_illegal = fetch_valid_in & (
        (fetch_addr_in <= intvec_pkg::PERIPH_TOP) |
        ((fetch_addr_in >= intvec_pkg::VACANT_LO) & (fetch_addr_in <= intvec_pkg::VACANT_HI)) |
        ((fetch_addr_in > RAM_TOP) & (fetch_addr_in < intvec_pkg::FLASH_BASE)) |
        (fetch_addr_in > FLASH_TOP));

    // every reset cause except power-up funnels into one event vector; power-up is loaded by reset
    assign rst_events = {fetch_illegal, pmm_password_in, flash_key_violation_flag_in,
                         wdt_password_in, wdt_timeout, ~pin_sync, 1'b0};

    // reading the reset word retires only the cause it reports
    assign cause_first = first_set({25'h000_0000, reset_cause});
    assign cause_clear = (vw_read_in && vw_sel_in == intvec_pkg::SEL_RESET &&
                          cause_first != 6'h00) ? 7'(7'h01 << (cause_first - 6'h01)) : 7'h00;

    // sticky causes; a new event in the clearing cycle wins over the clear
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reset_cause <= intvec_pkg::RST_CAUSE_RESET;
        end else begin
            reset_cause <= (reset_cause & ~cause_clear) | rst_events;
        end
    end

    // reset request to the core, vector fixed at the top word
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reset_req_out <= 1'b0;
        end else begin
            reset_req_out <= |rst_events;
        end
    end
    assign reset_vector_out = intvec_pkg::VEC_RESET;

    // non-maskable groups honour their own enables only, never gie
    assign snmi_active = snmi_flags_in & snmi_enable_in;
    assign unmi_active = unmi_flags_in & unmi_enable_in;

    // the watchdog slot bit is fed from interval-mode routing, not the bus
    assign wdt_mask = 73'(1) << intvec_pkg::SLOT_OFF[intvec_pkg::SLOT_WDT];
    assign flags_routed = (maskable_flags_in & ~wdt_mask) |
                          (wdt_interval_flag ? wdt_mask : 73'h0);
    assign active_flags = flags_routed & maskable_enable_in;

    // gather each slot's module flags; empty and absent slots stay zero
    for (genvar i = 0; i < intvec_pkg::NUM_SLOTS; i++) begin : g_slot
        for (genvar j = 0; j < intvec_pkg::SLOT_FLAG_W; j++) begin : g_bit
            if (j < intvec_pkg::SLOT_W[i] &&
                !(i == intvec_pkg::SLOT_CONV && !HAS_CONVERTER)) begin : g_used
                assign slot_flags[i][j] = active_flags[intvec_pkg::SLOT_OFF[i] + j];
            end else begin : g_none
                assign slot_flags[i][j] = 1'b0;
            end
        end
        assign slot_pend[i] = |slot_flags[i];
        assign slot_word[i] = word_code(first_set({16'h0000, slot_flags[i]}));
    end

    // slot 0 is the comparator and the highest maskable priority
    assign best_slot = first_set({12'h000, slot_pend});
    assign best_idx = 5'(best_slot - 6'h01);
    assign mask_req = gie_in & (best_slot != 6'h00);

    // fixed ranking: system nmi, then user nmi, then the best maskable slot
    assign cand_valid = (|snmi_active) | (|unmi_active) | mask_req;
    assign cand_vector = (|snmi_active) ? intvec_pkg::VEC_SNMI :
                         (|unmi_active) ? intvec_pkg::VEC_UNMI :
                         16'(intvec_pkg::VEC_MASK_TOP - {10'h000, best_idx, 1'b0});
    assign cand_prio = (|snmi_active) ? intvec_pkg::PRIO_SNMI :
                       (|unmi_active) ? intvec_pkg::PRIO_UNMI :
                       6'(intvec_pkg::PRIO_MASK_TOP - {1'b0, best_idx});

    // the request holds its vector until the core acknowledges; once every
    // source has disappeared while waiting, the request is withdrawn instead
    always_comb begin
        next_state = state;
        case (state)
            intvec_pkg::ARB_IDLE: begin
                if (cand_valid) begin
                    next_state = intvec_pkg::ARB_PEND;
                end
            end
            intvec_pkg::ARB_PEND: begin
                if (irq_ack_in || !cand_valid) begin
                    next_state = intvec_pkg::ARB_IDLE;
                end
            end
            default: begin
                next_state = intvec_pkg::ARB_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state <= intvec_pkg::ARB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // vector and priority are latched only when a new request is raised
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_req_out <= 1'b0;
            irq_vector_out <= intvec_pkg::VEC_RESET;
            irq_priority_out <= intvec_pkg::PRIO_RESET;
        end else begin
            irq_req_out <= (next_state == intvec_pkg::ARB_PEND);
            if (state == intvec_pkg::ARB_IDLE && cand_valid) begin
                irq_vector_out <= cand_vector;
                irq_priority_out <= cand_prio;
            end
        end
    end

    // wake from low power on any serviceable request; the core restores
    // its low-power bits on return, so nothing more is needed here
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wake_out <= 1'b0;
        end else begin
            wake_out <= lpm_in & cand_valid;
        end
    end

    // vector word read port, unknown selects read zero
    assign slot_sel = 5'(vw_sel_in - intvec_pkg::SEL_SLOT0);
    assign next_vw = (vw_sel_in == intvec_pkg::SEL_RESET) ? word_code(cause_first) :
                     (vw_sel_in == intvec_pkg::SEL_SNMI) ?
                         word_code(first_set({23'h00_0000, snmi_active})) :
                     (vw_sel_in == intvec_pkg::SEL_UNMI) ?
                         word_code(first_set({28'h000_0000, unmi_active})) :
                     (32'(slot_sel) < intvec_pkg::NUM_SLOTS) ? slot_word[slot_sel] :
                     16'h0000;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            vw_data_out <= 16'h0000;
        end else begin
            vw_data_out <= next_vw;
        end
    end

    // ---- checks ----
    property p_reset_req;
        @(posedge mclk_in) disable iff (rst_in)
        (|rst_events) |=> reset_req_out && reset_vector_out == 16'hFFFE;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("reset event not forwarded");

    property p_fetch_reset;
        @(posedge mclk_in) disable iff (rst_in)
        (fetch_valid_in && fetch_addr_in <= 20'h0_0FFF) |=> reset_req_out && reset_cause[6];
    endproperty
    a_fetch_reset: assert property (p_fetch_reset) else $error("illegal fetch gave no reset");

    property p_snmi_vector;
        @(posedge mclk_in) disable iff (rst_in)
        (state == intvec_pkg::ARB_IDLE && |(snmi_flags_in & snmi_enable_in)) |=>
            irq_req_out && irq_vector_out == 16'hFFFC && irq_priority_out == 6'h3E;
    endproperty
    a_snmi_vector: assert property (p_snmi_vector) else $error("system nmi vector wrong");

    property p_unmi_vector;
        @(posedge mclk_in) disable iff (rst_in)
        (state == intvec_pkg::ARB_IDLE && !(|(snmi_flags_in & snmi_enable_in)) &&
         |(unmi_flags_in & unmi_enable_in)) |=>
            irq_vector_out == 16'hFFFA && irq_priority_out == 6'h3D;
    endproperty
    a_unmi_vector: assert property (p_unmi_vector) else $error("user nmi vector wrong");

    property p_nmi_ignores_gie;
        @(posedge mclk_in) disable iff (rst_in)
        (!gie_in && |(unmi_flags_in & unmi_enable_in) && state == intvec_pkg::ARB_IDLE)
            |=> irq_req_out;
    endproperty
    a_nmi_ignores_gie: assert property (p_nmi_ignores_gie) else $error("nmi blocked by gie");

    property p_mask_map;
        @(posedge mclk_in) disable iff (rst_in)
        (irq_req_out && irq_priority_out <= 6'h3C) |->
            irq_vector_out == 16'(16'hFFF8 - {9'h000, 6'h3C - irq_priority_out, 1'b0});
    endproperty
    a_mask_map: assert property (p_mask_map) else $error("maskable vector off its priority");

    property p_no_low_vector;
        @(posedge mclk_in) disable iff (rst_in)
        irq_req_out |-> irq_priority_out >= 6'h29 && irq_vector_out != 16'hFFE6;
    endproperty
    a_no_low_vector: assert property (p_no_low_vector) else $error("reserved vector used");

    property p_hold_until_ack;
        @(posedge mclk_in) disable iff (rst_in)
        (irq_req_out && !irq_ack_in && cand_valid) |=> irq_req_out && $stable(irq_vector_out);
    endproperty
    a_hold_until_ack: assert property (p_hold_until_ack) else $error("request dropped early");

    property p_wake;
        @(posedge mclk_in) disable iff (rst_in)
        (lpm_in && |(snmi_flags_in & snmi_enable_in)) |=> wake_out;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on nmi");

    property p_word_empty;
        @(posedge mclk_in) disable iff (rst_in)
        (vw_sel_in == 5'h02 && (unmi_flags_in & unmi_enable_in) == 4'h0) |=> vw_data_out == 16'h0000;
    endproperty
    a_word_empty: assert property (p_word_empty) else $error("empty group word not zero");

    // with gie low and no nmi source the arbiter must stay quiet
    property p_gie_gate;
        @(posedge mclk_in) disable iff (rst_in)
        (state == intvec_pkg::ARB_IDLE && !gie_in &&
         (snmi_flags_in & snmi_enable_in) == 9'h000 && (unmi_flags_in & unmi_enable_in) == 4'h0)
            |=> !irq_req_out;
    endproperty
    a_gie_gate: assert property (p_gie_gate) else $error("maskable request passed gie");

    // interval-mode watchdog flag shows up in its own slot word
    property p_wdt_interval;
        @(posedge mclk_in) disable iff (rst_in)
        (wdt_interval_mode_in && watchdog_flag_in && vw_sel_in == 5'h06 &&
         maskable_enable_in[intvec_pkg::SLOT_OFF[intvec_pkg::SLOT_WDT]])
            |=> vw_data_out == 16'h0002;
    endproperty
    a_wdt_interval: assert property (p_wdt_interval) else $error("interval flag not in slot");

endmodule

// ==== tb/core_model.sv ====
`timescale 1ns/1ps

// core side: takes a raised request after a programmable stall
module core_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic irq_req_in,
    input wire logic [15:0] irq_vector_in,
    input wire logic [5:0] irq_priority_in,
    input wire logic [3:0] stall_in,
    output logic irq_ack_out,
    output logic [15:0] taken_vector_out,
    output logic [5:0] taken_priority_out,
    output int taken_count_out
);
    logic [3:0] wait_cnt;

    // ack launched off the falling edge so it is steady at the sampling edge; one cycle only
    always @(negedge clk_in) begin
        if (rst_in) begin
            irq_ack_out <= 1'b0;
            wait_cnt <= 4'h0;
            taken_count_out <= 0;
        end else if (irq_ack_out || !irq_req_in) begin
            irq_ack_out <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (wait_cnt == stall_in) begin
            irq_ack_out <= 1'b1;
            taken_vector_out <= irq_vector_in;
            taken_priority_out <= irq_priority_in;
            taken_count_out <= taken_count_out + 1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// ==== tb/tb_interrupt_vector_priority_map.sv ====
`timescale 1ns/1ps

module tb_interrupt_vector_priority_map;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic pin_n = 1'b1, wmode = 1'b0, wflag = 1'b0, wpass = 1'b0, fkey = 1'b0, ppass = 1'b0;
    logic [8:0] sflag = '0, sen = '1;
    logic [3:0] uflag = '0, uen = '1;
    logic [72:0] mflag = '0, men = '1;
    logic gie = 1'b0, lpm = 1'b0, fv = 1'b0, vrd = 1'b0;
    logic [19:0] faddr = 20'h0_4400;
    logic [4:0] vsel = 5'h00;
    logic [3:0] stall = 4'h0;
    logic req, rreq, wake, ack;
    logic [15:0] vec, rvec, vwd, tv;
    logic [5:0] prio, tp;
    int tc;
    int bad_count = 0;
    int samples_checked = 0;

    always #5 mclk = ~mclk;

    interrupt_vector_priority_map dut (
        .mclk_in(mclk), .rst_in(rst), .rst_pin_n_in(pin_n), .wdt_interval_mode_in(wmode),
        .watchdog_flag_in(wflag), .wdt_password_in(wpass), .flash_key_violation_flag_in(fkey),
        .pmm_password_in(ppass), .snmi_flags_in(sflag), .snmi_enable_in(sen),
        .unmi_flags_in(uflag), .unmi_enable_in(uen), .maskable_flags_in(mflag),
        .maskable_enable_in(men), .gie_in(gie), .lpm_in(lpm), .fetch_valid_in(fv),
        .fetch_addr_in(faddr), .irq_ack_in(ack), .vw_sel_in(vsel), .vw_read_in(vrd),
        .irq_req_out(req), .irq_vector_out(vec), .irq_priority_out(prio),
        .reset_req_out(rreq), .reset_vector_out(rvec), .wake_out(wake), .vw_data_out(vwd)
    );

    core_model core (
        .clk_in(mclk), .rst_in(rst), .irq_req_in(req), .irq_vector_in(vec),
        .irq_priority_in(prio), .stall_in(stall), .irq_ack_out(ack),
        .taken_vector_out(tv), .taken_priority_out(tp), .taken_count_out(tc)
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // bounded wait for the core to take one request, then judge what it loaded
    task automatic serve(input logic [15:0] ev, input logic [5:0] ep);
        int start;
        start = tc;
        for (int i = 0; i < 40 && tc == start; i++) @(negedge mclk);
        cmp(16'(tc - start), 16'h0001, "take count");
        cmp(tv, ev, "vector");
        cmp(16'(tp), 16'(ep), "priority");
    endtask

    // select is sampled at the next rising edge, the word is settled by the falling one
    task automatic vw_check(input logic [4:0] s, input logic [15:0] e);
        vsel = s;
        ticks(1);
        cmp(vwd, e, "vector word");
    endtask

    task automatic t_reset;
        cmp(16'(req), 16'h0000, "idle request");
        cmp(vec, 16'hFFFE, "reset vector");
        cmp(16'(prio), 16'h003F, "reset priority");
        cmp(rvec, 16'hFFFE, "start address");
        vw_check(5'h00, 16'h0002);
        $display("test reset done");
    endtask

    task automatic t_nmi;
        sflag[4] = 1'b1;
        serve(16'hFFFC, 6'h3E);
        sflag = '0;
        ticks(2);
        uflag[3] = 1'b1;
        serve(16'hFFFA, 6'h3D);
        // both groups raised with their own enables cleared
        sen = '0;
        uen = '0;
        sflag = '1;
        uflag = '1;
        ticks(4);
        cmp(16'(req), 16'h0000, "disabled nmi");
        sflag = '0;
        uflag = '0;
        sen = '1;
        uen = '1;
        ticks(2);
        $display("test nmi done");
    endtask

    // every sourced maskable slot in turn, the core stalling by varied amounts
    task automatic t_slots;
        gie = 1'b1;
        for (int i = 0; i < intvec_pkg::NUM_SLOTS; i++) begin
            if (i == intvec_pkg::SLOT_RSVD) continue;
            stall = 4'(i % 4);
            if (i == intvec_pkg::SLOT_WDT) begin
                wmode = 1'b1;
                wflag = 1'b1;
            end else begin
                mflag[intvec_pkg::SLOT_OFF[i]] = 1'b1;
            end
            if (i == intvec_pkg::SLOT_WDT) vw_check(5'h06, 16'h0002);
            serve(16'hFFF8 - 16'(2 * i), 6'h3C - 6'(i));
            wflag = 1'b0;
            mflag = '0;
            ticks(2);
        end
        gie = 1'b0;
        mflag = '1;
        ticks(4);
        cmp(16'(req), 16'h0000, "global gate");
        vw_check(5'h0C, 16'h0000);
        vw_check(5'h09, 16'h0002);
        mflag = '0;
        mflag[18] = 1'b1;
        mflag[20] = 1'b1;
        vw_check(5'h09, 16'h0008);
        vw_check(5'h19, 16'h0000);
        mflag = '0;
        vw_check(5'h09, 16'h0000);
        $display("test slots done");
    endtask

    // three sources raised together must be taken highest first, the rest left pending
    task automatic t_prio;
        int seen;
        gie = 1'b1;
        stall = 4'h2;
        uflag[0] = 1'b1;
        mflag[0] = 1'b1;
        mflag[44] = 1'b1;
        serve(16'hFFFA, 6'h3D);
        uflag = '0;
        serve(16'hFFF8, 6'h3C);
        mflag[0] = 1'b0;
        serve(16'hFFDE, 6'h2F);
        mflag = '0;
        ticks(2);
        // a request whose source vanishes before the slow core takes it is withdrawn
        stall = 4'hF;
        seen = tc;
        mflag[44] = 1'b1;
        ticks(3);
        cmp(16'(req), 16'h0001, "raised");
        mflag = '0;
        ticks(2);
        cmp(16'(req), 16'h0000, "withdrawn");
        cmp(16'(tc - seen), 16'h0000, "withdrawn take");
        $display("test priority done");
    endtask

    task automatic t_wake;
        lpm = 1'b1;
        stall = 4'hF;
        ticks(2);
        cmp(16'(wake), 16'h0000, "wake idle");
        mflag[44] = 1'b1;
        ticks(3);
        cmp(16'(wake), 16'h0001, "wake");
        serve(16'hFFDE, 6'h2F);
        mflag = '0;
        lpm = 1'b0;
        stall = 4'h0;
        gie = 1'b0;
        ticks(2);
        $display("test wake done");
    endtask

    task automatic t_rst;
        logic [19:0] fa [3] = '{20'h0_0100, 20'h0_1A00, 20'h0_4400};
        wmode = 1'b0;
        for (int k = 0; k < 3; k++) begin
            faddr = fa[k];
            fv = 1'b1;
            ticks(1);
            fv = 1'b0;
            cmp(16'(rreq), (k < 2) ? 16'h0001 : 16'h0000, "fetch reset");
            ticks(2);
        end
        wflag = 1'b1;
        wpass = 1'b1;
        fkey = 1'b1;
        ppass = 1'b1;
        ticks(1);
        cmp(16'(rreq), 16'h0001, "cause reset");
        {wflag, wpass, fkey, ppass} = 4'h0;
        pin_n = 1'b0;
        ticks(4);
        cmp(16'(rreq), 16'h0001, "pin reset");
        pin_n = 1'b1;
        ticks(4);
        // each read retires the reported cause, so the codes climb bit by bit
        vrd = 1'b1;
        for (int c = 0; c < 7; c++) vw_check(5'h00, 16'(2 * (c + 1)));
        vrd = 1'b0;
        vw_check(5'h00, 16'h0000);
        rst = 1'b1;
        ticks(2);
        rst = 1'b0;
        vw_check(5'h00, 16'h0002);
        $display("test reset causes done");
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        bad_count++;
        $display("unexpected at %0t: timeout", $time);
        end_sim();
    end

    initial begin
        ticks(8);
        rst = 1'b0;
        ticks(1);
        t_reset();
        t_nmi();
        t_slots();
        t_prio();
        t_wake();
        t_rst();
        end_sim();
    end
endmodule
